// [logic/illum_regs.svh]
// register map, reset values and timing figures of the illumination block
`ifndef ILLUM_REGS_SVH
`define ILLUM_REGS_SVH

`define REG_DW      16
`define REG_AW      4

`define ADDR_CTRL   4'h0
`define ADDR_AIG    4'h1
`define ADDR_LGAIN  4'h2
`define ADDR_LEDNOM 4'h3
`define ADDR_GAIN   4'h4
`define ADDR_PWR_R  4'h5
`define ADDR_PWR_G  4'h6
`define ADDR_PWR_B  4'h7
`define ADDR_FRAMES 4'h8
`define ADDR_SYNC   4'h9
`define ADDR_PSH    4'ha

`define CTRL_W      4
`define AIG_W       4
`define AIG_RST     4'h0
`define LGAIN_RST   8'h00
`define LED_NOM_RST 16'h0200
`define LED_MIN     16'h0001

`define CLK_MHZ     100
`define EYE_LEAD_US 1000
`define OFFSET_B_US 500
`define DELTA_D_NS  132000
`define PULSE_A_NS  26000

`endif

// [logic/illum_pkg.sv]
// shared types of the illumination and stereo sync block
package illum_pkg;
	typedef struct packed {
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
	} rgb_t;

	typedef struct packed {
		logic light_sync;
		logic stereo_en;
		logic local_region_gain_boost_en;
		logic content_adaptive_illumination_en;
	} ctrl_t;

	typedef logic [3:0] shift_t;
endpackage : illum_pkg

// [logic/eye_sync_timer.sv]
// eye-shutter sync timer: eye indicator, ir output and light sync pulse
module eye_sync_timer #(
	parameter int CW       = 24,
	parameter int LEAD_CYC = 100000,
	parameter int B_CYC    = 50000,
	parameter int D_CYC    = 13200,
	parameter int A_CYC    = 2600
) (
	input  wire logic i_clk,
	input  wire logic i_arst_n,
	input  wire logic i_ce,
	input  wire logic i_frame_start,
	input  wire logic i_enable,
	input  wire logic i_light_mode,
	output logic      o_eye_select,
	output logic      o_ir_sync,
	output logic      o_pulse_req,
	output logic      o_illum_blank
);
	localparam int C_CYC = B_CYC + D_CYC;

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic [CW-1:0] period;
		logic [CW-1:0] pw;
		logic          eye;
		logic          alt;
		logic          pulse;
		logic          blank;
		logic          ir;
	} sync_state_t;

	sync_state_t   s;
	sync_state_t   next_s;
	logic [CW-1:0] off;
	logic          lead_hit;
	logic          ir_cond;

	if (A_CYC < 1 || A_CYC >= B_CYC || C_CYC >= 2**(CW-1)
		|| LEAD_CYC >= 2**(CW-1)) begin : g_chk
		$error("eye_sync_timer: timing counts out of range");
	end

	// offset from frame end alternates between B and B+D
	assign off      = s.alt ? CW'(C_CYC) : CW'(B_CYC);
	assign lead_hit = s.cnt == s.period - CW'(LEAD_CYC);
	assign ir_cond  = i_enable & ~i_light_mode;

	always_comb begin
		next_s     = s;
		next_s.cnt = s.cnt + 1'b1;
		if (s.pulse) begin
			next_s.pw = s.pw - 1'b1;
			if (s.pw == '0)
				next_s.pulse = 1'b0;
		end
		// eye flips one lead time before the next frame edge
		if (lead_hit)
			next_s.eye = ~s.eye;
		if (i_light_mode && s.cnt == s.period - CW'(C_CYC))
			next_s.blank = 1'b1;
		if (i_light_mode && s.cnt == s.period - off) begin
			next_s.pulse = 1'b1;
			next_s.pw    = CW'(A_CYC - 1);
		end
		if (i_frame_start) begin
			next_s.period = s.cnt + 1'b1;
			next_s.cnt    = '0;
			next_s.alt    = ~s.alt;
			next_s.blank  = 1'b0;
			next_s.pulse  = 1'b0;
		end
		if (!i_enable) begin
			next_s.eye   = 1'b0;
			next_s.pulse = 1'b0;
			next_s.blank = 1'b0;
		end
		next_s.ir = ir_cond & next_s.eye;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			s <= '0;
		else if (i_ce)
			s <= next_s;
	end

	assign o_eye_select  = s.eye;
	assign o_ir_sync     = s.ir;
	assign o_pulse_req   = s.pulse;
	assign o_illum_blank = s.blank;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	pulse_in_blank_a: assert property (
		o_pulse_req |-> o_illum_blank)
		else $error("light pulse outside the dark interval");
	pulse_len_a: assert property (
		$rose(o_pulse_req) |-> s.pw == CW'(A_CYC - 1))
		else $error("light pulse started with wrong width");
	pulse_slot_a: assert property (
		$rose(o_pulse_req) |->
		$past(s.cnt) == $past(s.period) - $past(off))
		else $error("light pulse not at its frame offset");
	eye_lead_a: assert property (
		$changed(o_eye_select) && $past(i_enable) |-> $past(lead_hit))
		else $error("eye indicator toggled off its lead point");
	ir_follow_a: assert property (
		$past(i_ce) |->
		o_ir_sync == ($past(ir_cond) && o_eye_select))
		else $error("ir sync output does not follow eye");
endmodule : eye_sync_timer

// [logic/adaptive_illum_and_stereo_sync.sv]
// content adaptive illumination, local boost and stereo sync core
`include "illum_regs.svh"

module adaptive_illum_and_stereo_sync #(
	parameter int LW       = 10,
	parameter int NREG     = 4,
	parameter int SW       = 28,
	parameter int CW       = 24,
	parameter int LEAD_CYC = `EYE_LEAD_US * `CLK_MHZ,
	parameter int B_CYC    = `OFFSET_B_US * `CLK_MHZ,
	parameter int D_CYC    = (`DELTA_D_NS * `CLK_MHZ + 999) / 1000,
	parameter int A_CYC    = (`PULSE_A_NS * `CLK_MHZ + 999) / 1000
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_arst_n,
	input  wire logic                  i_ce,
	input  wire logic [`REG_AW-1:0]    i_addr,
	input  wire logic [`REG_DW-1:0]    i_wdata,
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	output logic [`REG_DW-1:0]         o_rdata,
	input  wire logic                  i_frame_start,
	input  wire logic                  i_stereo_active,
	input  wire logic                  i_pix_valid,
	input  wire illum_pkg::rgb_t       i_pix,
	input  wire logic [$clog2(NREG)-1:0] i_region,
	output logic                       o_pix_valid,
	output illum_pkg::rgb_t            o_pix,
	output logic [2:0][3:0]            o_gain_shift,
	output logic [2:0][LW-1:0]         o_led_power,
	output logic [NREG-1:0][7:0]       o_region_gain,
	output logic                       o_eye_select,
	output logic                       o_ir_sync,
	output logic                       o_pulse_req,
	output logic                       o_illum_blank
);
	localparam int RW    = $clog2(NREG);
	localparam int TW    = SW + RW;
	localparam logic [LW-1:0] LED_MIN = LW'(`LED_MIN);
	localparam logic [LW-1:0] LED_NOM = LW'(`LED_NOM_RST);

	typedef struct packed {
		illum_pkg::ctrl_t           ctrl;
		illum_pkg::shift_t          aig;
		logic [7:0]                 lgain;
		logic [LW-1:0]              led_nom;
		logic [2:0][7:0]            peak;
		logic [NREG-1:0][SW-1:0]    sum;
		logic [2:0][3:0]            gsh;
		logic [2:0][3:0]            psh;
		logic [2:0][LW-1:0]         pwr;
		logic [NREG-1:0][7:0]       rgain;
		logic [15:0]                frames;
		logic [`REG_DW-1:0]         rdata;
		logic                       pvalid;
		illum_pkg::rgb_t            pix;
	} core_state_t;

	localparam core_state_t RST_S = '{
		aig:     `AIG_RST,
		lgain:   `LGAIN_RST,
		led_nom: LED_NOM,
		pwr:     {3{LED_NOM}},
		default: '0
	};

	core_state_t           s;
	core_state_t           next_s;
	logic [2:0][7:0]       in_arr;
	wire  [2:0][7:0]       sat_arr;
	wire  [2:0][7:0]       new_pk;
	wire  [2:0][3:0]       lz;
	wire  [2:0][3:0]       psh;
	wire  [2:0][LW-1:0]    fpwr;
	illum_pkg::shift_t     common;
	wire  [NREG:0][TW-1:0] acc;
	wire  [NREG-1:0][SW-1:0] sum_inc;
	wire  [NREG-1:0]       hit;
	wire  [NREG-1:0]       dim;
	logic                  sync_en;
	logic                  fs_ce;

	if (NREG < 2 || NREG > 16 || (NREG & (NREG - 1)) != 0
		|| LW < 4 || LW > 16 || SW < 18 || SW > 32) begin : g_chk
		$error("adaptive_illum: parameter out of range");
	end

	function automatic illum_pkg::shift_t lead0(input logic [7:0] v);
		lead0 = 4'h8;
		for (int i = 0; i < 8; i++) begin
			if (v[i])
				lead0 = 4'(7 - i);
		end
	endfunction : lead0

	function automatic illum_pkg::shift_t min_sh(
		input illum_pkg::shift_t a,
		input illum_pkg::shift_t b
	);
		min_sh = (a < b) ? a : b;
	endfunction : min_sh

	assign in_arr = i_pix;
	assign fs_ce  = i_frame_start & i_ce;
	// common boost: no channel may be pushed past its own headroom
	assign common = min_sh(min_sh(s.aig, lz[0]), min_sh(lz[1], lz[2]));

	for (genvar c = 0; c < 3; c++) begin : g_ch
		logic [15:0]   wide;
		logic [LW-1:0] sh_pwr;

		assign wide        = {8'h00, in_arr[c]} << s.gsh[c];
		assign sat_arr[c]  = (|wide[15:8]) ? 8'hff : wide[7:0];
		assign new_pk[c]   = (in_arr[c] > s.peak[c]) ? in_arr[c] : s.peak[c];
		assign lz[c]       = lead0(s.peak[c]);
		// headroom beyond the boost setting becomes led power saving
		assign psh[c]      = (lz[c] > s.aig) ? lz[c] - s.aig : 4'h0;
		assign sh_pwr      = s.led_nom >> psh[c];
		assign fpwr[c]     = (s.peak[c] == 8'h00 || sh_pwr < LED_MIN)
			? LED_MIN : sh_pwr;

		black_min_a: assert property (
			@(posedge i_clk) disable iff (!i_arst_n)
			(fs_ce && s.ctrl.content_adaptive_illumination_en && s.peak[c] == 8'h00)
			|=> o_led_power[c] == LED_MIN)
			else $error("black content did not give minimum led power");
		white_nom_a: assert property (
			@(posedge i_clk) disable iff (!i_arst_n)
			(fs_ce && s.ctrl.content_adaptive_illumination_en && s.peak[c] == 8'hff)
			|=> o_led_power[c] == $past(s.led_nom)
			&& o_gain_shift[c] == 4'h0)
			else $error("white content did not give nominal led power");
	end

	assign acc[0] = '0;
	for (genvar r = 0; r < NREG; r++) begin : g_reg
		assign acc[r+1]   = acc[r] + TW'(s.sum[r]);
		assign hit[r]     = i_pix_valid && i_region == RW'(r);
		assign sum_inc[r] = s.sum[r] + SW'(hit[r] ? in_arr[1] : 8'h00);
		// equal-size regions assumed, so sum times count versus total
		assign dim[r]     = {s.sum[r], {RW{1'b0}}} < acc[NREG];

		local_region_gain_boost_dim_a: assert property (
			@(posedge i_clk) disable iff (!i_arst_n)
			(fs_ce && s.ctrl.local_region_gain_boost_en && dim[r])
			|=> o_region_gain[r] == $past(s.lgain))
			else $error("dim region did not receive local gain");
	end

	always_comb begin
		next_s        = s;
		next_s.rdata  = '0;
		next_s.pvalid = i_pix_valid;
		if (i_wr) begin
			case (i_addr)
				`ADDR_CTRL: begin
					next_s.ctrl = illum_pkg::ctrl_t'(i_wdata[`CTRL_W-1:0]);
				end
				`ADDR_AIG: begin
					next_s.aig = i_wdata[`AIG_W-1:0];
				end
				`ADDR_LGAIN: begin
					next_s.lgain = i_wdata[7:0];
				end
				`ADDR_LEDNOM: begin
					next_s.led_nom = i_wdata[LW-1:0];
				end
				default: begin
				end
			endcase
		end
		if (i_rd) begin
			case (i_addr)
				`ADDR_CTRL:   next_s.rdata = `REG_DW'(s.ctrl);
				`ADDR_AIG:    next_s.rdata = `REG_DW'(s.aig);
				`ADDR_LGAIN:  next_s.rdata = `REG_DW'(s.lgain);
				`ADDR_LEDNOM: next_s.rdata = `REG_DW'(s.led_nom);
				`ADDR_GAIN:   next_s.rdata = `REG_DW'(s.gsh);
				`ADDR_PWR_R:  next_s.rdata = `REG_DW'(s.pwr[2]);
				`ADDR_PWR_G:  next_s.rdata = `REG_DW'(s.pwr[1]);
				`ADDR_PWR_B:  next_s.rdata = `REG_DW'(s.pwr[0]);
				`ADDR_FRAMES: next_s.rdata = s.frames;
				`ADDR_SYNC: begin
					next_s.rdata = `REG_DW'({o_illum_blank, o_pulse_req,
						o_ir_sync, o_eye_select});
				end
				`ADDR_PSH:    next_s.rdata = `REG_DW'(s.psh);
				default:      next_s.rdata = '0;
			endcase
		end
		if (i_pix_valid) begin
			next_s.pix  = sat_arr;
			next_s.peak = new_pk;
		end
		next_s.sum = sum_inc;
		// settings from the finished frame land together on its edge
		if (i_frame_start) begin
			for (int c = 0; c < 3; c++) begin
				if (s.ctrl.content_adaptive_illumination_en) begin
					next_s.gsh[c] = common + psh[c];
					next_s.psh[c] = psh[c];
					next_s.pwr[c] = fpwr[c];
				end else begin
					next_s.gsh[c] = 4'h0;
					next_s.psh[c] = 4'h0;
					next_s.pwr[c] = s.led_nom;
				end
			end
			for (int r = 0; r < NREG; r++) begin
				next_s.rgain[r] = (s.ctrl.local_region_gain_boost_en && dim[r])
					? s.lgain : 8'h00;
				next_s.sum[r]   = hit[r] ? SW'(in_arr[1]) : '0;
			end
			next_s.peak   = i_pix_valid ? in_arr : '0;
			next_s.frames = s.frames + 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			s <= RST_S;
		else if (i_ce)
			s <= next_s;
	end

	assign o_rdata       = s.rdata;
	assign o_pix_valid   = s.pvalid;
	assign o_pix         = s.pix;
	assign o_gain_shift  = s.gsh;
	assign o_led_power   = s.pwr;
	assign o_region_gain = s.rgain;
	assign sync_en       = s.ctrl.stereo_en & i_stereo_active;

	eye_sync_timer #(
		.CW       (CW),
		.LEAD_CYC (LEAD_CYC),
		.B_CYC    (B_CYC),
		.D_CYC    (D_CYC),
		.A_CYC    (A_CYC)
	) u_sync (
		.i_clk         (i_clk),
		.i_arst_n      (i_arst_n),
		.i_ce          (i_ce),
		.i_frame_start (i_frame_start),
		.i_enable      (sync_en),
		.i_light_mode  (s.ctrl.light_sync),
		.o_eye_select  (o_eye_select),
		.o_ir_sync     (o_ir_sync),
		.o_pulse_req   (o_pulse_req),
		.o_illum_blank (o_illum_blank)
	);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	sequence calc_s;
		fs_ce && s.ctrl.content_adaptive_illumination_en;
	endsequence

	sequence bright_s;
		calc_s ##0 (s.aig >= 4'h8 && lz[0] < 4'h8 && lz[1] < 4'h8
			&& lz[2] < 4'h8);
	endsequence

	colour_balance_a: assert property (
		(o_gain_shift[0] - s.psh[0] == o_gain_shift[1] - s.psh[1])
		&& (o_gain_shift[1] - s.psh[1] == o_gain_shift[2] - s.psh[2]))
		else $error("gain and power shifts unbalanced across channels");
	bright_power_a: assert property (
		bright_s |=> o_led_power == {3{$past(s.led_nom)}})
		else $error("brightness mode changed led power");
	frame_hold_a: assert property (
		($changed(o_gain_shift) || $changed(o_led_power))
		|-> $past(fs_ce))
		else $error("gain or power changed inside a frame");
	unmapped_rd_a: assert property (
		(i_rd && i_ce && i_addr > `ADDR_PSH) |=> o_rdata == '0)
		else $error("unmapped read returned data");
endmodule : adaptive_illum_and_stereo_sync

// [tb/illum_driver_model.sv]
// far-side model: light driver and glasses watching pulse, dark gap and eye
module illum_driver_model (
	input  wire logic i_clk,
	input  wire logic i_frame_start,
	input  wire logic i_pulse_req,
	input  wire logic i_illum_blank,
	input  wire logic i_eye_select,
	input  wire logic i_ir_sync,
	output int        o_pulses,
	output int        o_eyes,
	output int        o_irs,
	output int        o_ppos,
	output int        o_epos,
	output int        o_bpos,
	output int        o_bad
);
	timeunit 1ns;
	timeprecision 1ns;
	int   cnt = 0, np = 0, ne = 0, ni = 0;
	logic p_q = 0, b_q = 0, e_q = 0, i_q = 0;
	// the driver lights the pulse in red, never blue, for the glasses
	localparam logic [2:0] PULSE_RGB = 3'b100;
	// counts are per frame except o_bad, which never clears; positions are cycles after the frame edge
	always @(posedge i_clk) begin
		p_q <= i_pulse_req;
		b_q <= i_illum_blank;
		e_q <= i_eye_select;
		i_q <= i_ir_sync;
		cnt <= i_frame_start ? 0 : cnt + 1;
		if (i_frame_start) begin
			o_pulses <= np;
			o_eyes <= ne;
			o_irs <= ni;
			np <= 0;
			ne <= 0;
			ni <= 0;
		end else begin
			if (i_pulse_req && !p_q) begin
				np <= np + 1;
				o_ppos <= cnt;
			end
			if (i_illum_blank && !b_q) o_bpos <= cnt;
			if (i_eye_select != e_q) begin
				ne <= ne + 1;
				o_epos <= cnt;
			end
			if (i_ir_sync != i_q) ni <= ni + 1;
		end
		// the source may light up only for the pulse inside the dark gap
		if (i_pulse_req && !i_illum_blank) o_bad <= o_bad + 1;
	end
endmodule : illum_driver_model

// [tb/testbench.sv]
// self-checking bench of the adaptive illumination and stereo sync core
`include "illum_regs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int P = 200;
	logic i_clk = 0, i_arst_n = 0, i_wr = 0, i_rd = 0, i_frame_start = 0;
	logic i_stereo_active = 0, i_pix_valid = 0, rd_d = 0, fs_d = 0;
	logic [3:0] i_addr = 0, aig = 0, ctrl = 0, sh = 0;
	logic [15:0] i_wdata = 0, o_rdata;
	logic [1:0] i_region = 0;
	logic [7:0] peak = 0, lgain = 0;
	illum_pkg::rgb_t i_pix = '0, o_pix;
	logic o_pix_valid, o_eye_select, o_ir_sync, o_pulse_req, o_illum_blank;
	logic [2:0][3:0] o_gain_shift;
	logic [2:0][9:0] o_led_power;
	logic [3:0][7:0] o_region_gain;
	logic [73:0] last_fr = {12'h000, {3{10'h200}}, 32'h0000_0000};
	logic [15:0] q_rd[$];
	logic [23:0] q_px[$];
	logic [73:0] q_fr[$];
	logic [15:0] tbl[7] = '{16'h3040, 16'h3810, 16'h31ff, 16'h3000,
		16'h3110, 16'h2040, 16'h3420};
	int error_cnt = 0, num_checks = 0, last_pp = 0;
	int pulses, eyes, irs, ppos, epos, bpos, bad;

	always #5 i_clk = ~i_clk;

	// short pulse so that the dark gap fits the short bench frames
	adaptive_illum_and_stereo_sync #(.LEAD_CYC(40), .B_CYC(20), .D_CYC(8),
		.A_CYC(4))
	adaptive_illum_and_stereo_sync_i (.i_clk, .i_arst_n, .i_ce(1'b1),
		.i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_frame_start,
		.i_stereo_active, .i_pix_valid, .i_pix, .i_region, .o_pix_valid,
		.o_pix, .o_gain_shift, .o_led_power, .o_region_gain, .o_eye_select,
		.o_ir_sync, .o_pulse_req, .o_illum_blank);

	illum_driver_model illum_driver_model_i (.i_clk, .i_frame_start,
		.i_pulse_req(o_pulse_req), .i_illum_blank(o_illum_blank),
		.i_eye_select(o_eye_select), .i_ir_sync(o_ir_sync),
		.o_pulses(pulses), .o_eyes(eyes), .o_irs(irs), .o_ppos(ppos),
		.o_epos(epos), .o_bpos(bpos), .o_bad(bad));

	task automatic check(input logic [73:0] got, input logic [73:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// results are sampled one edge after the request that caused them
	always @(posedge i_clk) begin
		rd_d <= i_rd;
		fs_d <= i_frame_start;
		if (rd_d) check(o_rdata, q_rd.pop_front());
		if (o_pix_valid) check(o_pix, q_px.pop_front());
		if (fs_d) check({o_gain_shift, o_led_power, o_region_gain},
			q_fr.pop_front());
	end

	// both strobes assigned once per call, so calls may follow back to back
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [15:0] d);
		if (!w) q_rd.push_back(d);
		i_wr <= w;
		i_rd <= !w;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
	endtask : bus

	task automatic idle;
		i_wr <= 0;
		i_rd <= 0;
		@(posedge i_clk);
	endtask : idle

	function automatic logic [7:0] sat(input logic [7:0] x);
		return ({8'h00, x} << sh) > 16'h00ff ? 8'hff : x << sh;
	endfunction : sat

	function automatic logic near(input int v, input int c);
		return v >= c - 1 && v <= c + 2;
	endfunction : near

	function automatic logic [73:0] exp_fr(input logic [7:0] pk);
		int lz, psh, g, pw;
		lz = 8;
		for (int i = 0; i < 8; i++) if (pk[i]) lz = 7 - i;
		psh = lz > aig ? lz - aig : 0;
		g = (aig < lz ? aig : lz) + psh;
		pw = `LED_NOM_RST >> psh;
		if (pk == 0 || pw == 0) pw = 1;
		if (!ctrl[0]) begin
			g = 0;
			pw = `LED_NOM_RST;
		end
		return {{3{4'(g)}}, {3{10'(pw)}}, 24'h00_0000,
			ctrl[1] && pk != 0 ? lgain : 8'h00};
	endfunction : exp_fr

	// one frame of P cycles; region 0 is kept dim, green carries the peak
	task automatic frame(input logic [7:0] pk);
		logic [7:0] r, g, b;
		check({o_gain_shift, o_led_power, o_region_gain}, last_fr);
		last_fr = exp_fr(peak);
		q_fr.push_back(last_fr);
		sh = last_fr[73:70];
		peak = pk;
		i_frame_start <= 1;
		@(posedge i_clk);
		i_frame_start <= 0;
		for (int k = 0; k < 16; k++) begin
			g = k[1:0] == 2'b00 ? 8'(pk != 0) : pk;
			r = k == 1 ? pk : 8'($urandom % (pk + 1));
			b = k == 1 ? pk : 8'($urandom % (pk + 1));
			i_pix_valid <= 1;
			i_pix <= {r, g, b};
			i_region <= k[1:0];
			q_px.push_back({sat(r), sat(g), sat(b)});
			@(posedge i_clk);
		end
		i_pix_valid <= 0;
		repeat (P - 17) @(posedge i_clk);
	endtask : frame

	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop

	initial begin
		void'($urandom(32'h747b_fd48));
		repeat (4) @(posedge i_clk);
		i_arst_n <= 1;
		@(posedge i_clk);
		bus(0, `ADDR_CTRL, 16'h0000);
		bus(0, `ADDR_AIG, 16'h0000);
		bus(0, `ADDR_LGAIN, 16'h0000);
		bus(0, `ADDR_LEDNOM, `LED_NOM_RST);
		bus(0, 4'hf, 16'h0000);
		bus(1, `ADDR_GAIN, 16'hffff);
		bus(0, `ADDR_GAIN, 16'h0000);
		foreach (tbl[i]) begin
			ctrl = tbl[i][15:12];
			aig = tbl[i][11:8];
			lgain = 8'($urandom);
			bus(1, `ADDR_CTRL, 16'(ctrl));
			bus(1, `ADDR_AIG, 16'(aig));
			bus(1, `ADDR_LGAIN, 16'(lgain));
			bus(0, `ADDR_AIG, 16'(aig));
			idle;
			frame(tbl[i][7:0]);
		end
		ctrl = 4'hf;
		i_stereo_active <= 1;
		bus(1, `ADDR_CTRL, 16'(ctrl));
		idle;
		for (int f = 0; f < 12; f++) begin
			if (f == 6) begin
				ctrl = 4'h7;
				bus(1, `ADDR_CTRL, 16'(ctrl));
				idle;
			end
			if (f == 9) i_stereo_active <= 0;
			frame(8'h80);
			if (f >= 2 && f < 6) begin
				check(pulses, 1);
				check(irs, 0);
				check(bad, 0);
				check(near(P - bpos, 28) && bpos <= ppos, 1);
				check(near(P - epos, 40), 1);
				if (f > 2) check(ppos > last_pp ? ppos - last_pp
					: last_pp - ppos, 8);
				last_pp = ppos;
			end
			if (f == 7 || f == 8) begin
				check(irs, 1);
				check(eyes, 1);
				check(pulses, 0);
			end
			if (f == 11) check(eyes + irs + pulses, 0);
		end
		repeat (3) @(posedge i_clk);
		report_and_stop;
	end
endmodule : testbench
